//--- uafc_top.sv
// UART enhanced feature, flow control and reset state register block
`timescale 1ns/10ps
// Overview of operation
// [R1] Scratch byte stores and returns eight bits
// [R2] Auto CTS halts transmitter while CTS high
// [R3] Halt only between characters, never mid-character
// [R4] Auto RTS interrupt at programmed trigger level
// [R5] RTS pin high at next trigger level
// [R6] RTS low below next lower trigger level
// [R7] Without auto RTS, pin follows modem control
// [R8] Auto RTS bit reads flow control status
// [R9] Enhanced bits five to zero reserved
// [R10] Control registers clear to zero on reset
// [R11] Interrupt status resets to no pending
// [R12] Line status resets with empty flags set
// [R13] Modem status shows pins, deltas cleared
// [R14] Reset drives TX, RTS, DTR high; DMA pins
module uafc_top
  import uafc_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [APB_AW-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              cts_n_i,
  input  wire logic              dsr_n_i,
  input  wire logic              ri_n_i,
  input  wire logic              dcd_n_i,
  input  wire logic              tx_serial_i,
  input  wire logic              tx_active_i,
  input  wire logic [6:0]        int_ident_i,
  input  wire logic              int_pending_i,
  input  wire logic [7:0]        line_status_i,
  input  wire logic [LVL_W-1:0]  rx_level_i,
  input  wire logic              tx_fifo_full_i,
  output logic                   tx_o,
  output logic                   rts_n_o,
  output logic                   dtr_n_o,
  output logic                   rx_dma_ready_o,
  output logic                   tx_dma_ready_o,
  output logic                   tx_halt_o,
  output logic [7:0]             interrupt_enable_reg_o,
  output logic [7:0]             line_control_reg_o,
  output logic [7:0]             fifo_control_reg_o,
  output logic                   int_o
);
  // Pins arrive from the modem side unsynchronised
  logic [3:0] pin_s;
  logic       cts_s;
  logic       dsr_s;
  logic       ri_s;
  logic       dcd_s;

  uafc_sync #(
    .W       (4),
    .RST_VAL (4'hF)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({dcd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
    .sync_o    (pin_s)
  );
  assign {dcd_s, ri_s, dsr_s, cts_s} = pin_s;

  // Control and status registers
  logic [7:0] ier_r, ier_nxt;
  logic [7:0] lcr_r, lcr_nxt;
  logic [7:0] mcr_r, mcr_nxt;
  logic [7:0] fcr_r, fcr_nxt;
  logic [7:0] scr_r, scr_nxt;
  logic [1:0] efr_r, efr_nxt;
  logic [7:0] isr_r, isr_nxt;
  logic [7:0] lsr_r, lsr_nxt;
  logic [3:0] mdelta_r, mdelta_nxt;
  logic [3:0] mup_r, mup_nxt;
  logic [EV_N-1:0] istat_r, istat_nxt;
  logic [EV_N-1:0] imask_r, imask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        err_r, err_nxt;
  logic        halt_r, halt_nxt;
  logic        tx_r, tx_nxt;
  logic        rx_dma_ready_r, rx_dma_ready_nxt;
  logic        tx_dma_ready_r, tx_dma_ready_nxt;
  logic        int_r, int_nxt;
  logic        hit_d_r, hit_d_nxt;
  logic        hold_d_r, hold_d_nxt;

  logic [3:0]  msr_up;
  logic [7:0]  msr_val;
  logic [7:0]  efr_val;
  logic [EV_N-1:0] ev;
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic        mapped;

  uafc_flow_if flow ();
  assign flow.enable   = efr_r[EFR_RTS - 6];
  assign flow.trig_sel = fcr_r[FCR_TRH:FCR_TRL];
  assign flow.level    = rx_level_i;

  uafc_rts u_rts (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .fl        (flow.flow)
  );

  // Loopback feeds modem status from the modem control outputs
  always_comb begin
    if (mcr_r[MCR_LOOP]) begin
      msr_up = {mcr_r[MCR_OUT2], mcr_r[MCR_OUT1],
                mcr_r[MCR_DTR], mcr_r[MCR_RTS]};
    end else begin
      msr_up = {~dcd_s, ~ri_s, ~dsr_s, ~cts_s}; // [R13]
    end
  end
  assign msr_val = {msr_up, mdelta_r};

  // Enable bit reads back as the live throttle state
  assign efr_val = {efr_r[1], efr_r[0] & flow.rts_hold, 6'h00}; // [R8] [R9]

  assign setup  = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign wr     = access && pwrite_i && pstrb_i[0];
  assign rd     = access && !pwrite_i;

  always_comb begin
    unique case (paddr_i)
      OFS_IER, OFS_ISR, OFS_LCR, OFS_MCR, OFS_LSR, OFS_MSR,
      OFS_FCR, OFS_SCR, OFS_EFR, OFS_ISTAT, OFS_IMASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured in setup so the access phase answers from flops
  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (setup) begin
      err_nxt   = !mapped;
      rdata_nxt = 32'h0000_0000;
      unique case (paddr_i)
        OFS_IER:   rdata_nxt[7:0] = ier_r;
        OFS_ISR:   rdata_nxt[7:0] = isr_r;
        OFS_LCR:   rdata_nxt[7:0] = lcr_r;
        OFS_MCR:   rdata_nxt[7:0] = mcr_r;
        OFS_LSR:   rdata_nxt[7:0] = lsr_r;
        OFS_MSR:   rdata_nxt[7:0] = msr_val;
        OFS_FCR:   rdata_nxt[7:0] = fcr_r;
        OFS_SCR:   rdata_nxt[7:0] = scr_r; // [R1]
        OFS_EFR:   rdata_nxt[7:0] = efr_val;
        OFS_ISTAT: rdata_nxt[EV_N-1:0] = istat_r;
        OFS_IMASK: rdata_nxt[EV_N-1:0] = imask_r;
        default:   rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Software writes take effect on the access edge
  always_comb begin
    ier_nxt   = ier_r;
    lcr_nxt   = lcr_r;
    mcr_nxt   = mcr_r;
    fcr_nxt   = fcr_r;
    scr_nxt   = scr_r;
    efr_nxt   = efr_r;
    imask_nxt = imask_r;
    if (wr) begin
      unique case (paddr_i)
        OFS_IER:   ier_nxt = pwdata_i[7:0];
        OFS_LCR:   lcr_nxt = pwdata_i[7:0];
        OFS_MCR:   mcr_nxt = pwdata_i[7:0];
        OFS_FCR:   fcr_nxt = pwdata_i[7:0];
        OFS_SCR:   scr_nxt = pwdata_i[7:0]; // [R1]
        OFS_EFR:   efr_nxt = pwdata_i[EFR_CTS:EFR_RTS]; // [R9]
        OFS_IMASK: imask_nxt = pwdata_i[EV_N-1:0];
        default:   ier_nxt = ier_r;
      endcase
    end
  end

  // Modem change flags: a change in the read cycle is kept
  always_comb begin
    mup_nxt    = msr_up;
    mdelta_nxt = mdelta_r;
    if (rd && paddr_i == OFS_MSR) begin
      mdelta_nxt = 4'h0;
    end
    mdelta_nxt[3] = mdelta_nxt[3] | (msr_up[3] ^ mup_r[3]);
    mdelta_nxt[2] = mdelta_nxt[2] | (mup_r[2] & ~msr_up[2]);
    mdelta_nxt[1] = mdelta_nxt[1] | (msr_up[1] ^ mup_r[1]);
    mdelta_nxt[0] = mdelta_nxt[0] | (msr_up[0] ^ mup_r[0]);
  end

  // Halt is granted only when no character is on the wire
  assign halt_nxt = efr_r[EFR_CTS - 6] && cts_s && // [R2]
                    (halt_r || !tx_active_i); // [R3]

  assign hit_d_nxt  = flow.trig_hit;
  assign hold_d_nxt = flow.rts_hold;

  always_comb begin
    ev          = '0;
    ev[EV_TRIG] = flow.trig_hit && !hit_d_r; // [R4]
    ev[EV_HALT] = halt_nxt && !halt_r;
    ev[EV_RTS]  = flow.rts_hold && !hold_d_r;
    ev[EV_MDM]  = |(mdelta_nxt & ~mdelta_r);
  end

  // Set beats a write-one clear in the same cycle
  always_comb begin
    istat_nxt = istat_r;
    if (wr && paddr_i == OFS_ISTAT) begin
      istat_nxt = istat_r & ~pwdata_i[EV_N-1:0];
    end
    istat_nxt = istat_nxt | ev;
  end

  assign isr_nxt = {int_ident_i, ~int_pending_i};
  assign lsr_nxt = line_status_i;
  assign tx_nxt  = tx_serial_i && !lcr_r[LCR_BRK];
  assign int_nxt = |(istat_nxt & imask_nxt);

  // Single transfer mode tracks data ready and holding empty
  always_comb begin
    if (fcr_r[FCR_DMA]) begin
      rx_dma_ready_nxt = !flow.trig_hit;
      tx_dma_ready_nxt = tx_fifo_full_i;
    end else begin
      rx_dma_ready_nxt = !lsr_r[LSR_RDR];
      tx_dma_ready_nxt = !lsr_r[LSR_THRE];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ier_r    <= RST_ZERO; // [R10]
      lcr_r    <= RST_ZERO; // [R10]
      mcr_r    <= RST_ZERO; // [R10]
      fcr_r    <= RST_ZERO; // [R10]
      efr_r    <= '0; // [R10]
      scr_r    <= RST_ZERO;
      isr_r    <= RST_ISR; // [R11]
      lsr_r    <= RST_LSR; // [R12]
      mdelta_r <= '0; // [R13]
      mup_r    <= '0;
      istat_r  <= '0;
      imask_r  <= '0;
      rdata_r  <= 32'h0000_0000;
      err_r    <= 1'b0;
      halt_r   <= 1'b0;
      tx_r     <= 1'b1; // [R14]
      rx_dma_ready_r  <= 1'b1; // [R14]
      tx_dma_ready_r  <= 1'b0; // [R14]
      int_r    <= 1'b0; // [R14]
      hit_d_r  <= 1'b0;
      hold_d_r <= 1'b0;
    end else begin
      ier_r    <= ier_nxt;
      lcr_r    <= lcr_nxt;
      mcr_r    <= mcr_nxt;
      fcr_r    <= fcr_nxt;
      efr_r    <= efr_nxt;
      scr_r    <= scr_nxt;
      isr_r    <= isr_nxt;
      lsr_r    <= lsr_nxt;
      mdelta_r <= mdelta_nxt;
      mup_r    <= mup_nxt;
      istat_r  <= istat_nxt;
      imask_r  <= imask_nxt;
      rdata_r  <= rdata_nxt;
      err_r    <= err_nxt;
      halt_r   <= halt_nxt;
      tx_r     <= tx_nxt;
      rx_dma_ready_r  <= rx_dma_ready_nxt;
      tx_dma_ready_r  <= tx_dma_ready_nxt;
      int_r    <= int_nxt;
      hit_d_r  <= hit_d_nxt;
      hold_d_r <= hold_d_nxt;
    end
  end

  // Pin is active low; auto mode overrides the modem control bit
  assign rts_n_o = efr_r[EFR_RTS - 6] ? flow.rts_hold // [R5] [R6]
                                      : !mcr_r[MCR_RTS]; // [R7] [R14]
  assign dtr_n_o = !mcr_r[MCR_DTR]; // [R14]
  assign tx_o           = tx_r;
  assign rx_dma_ready_o = rx_dma_ready_r;
  assign tx_dma_ready_o = tx_dma_ready_r;
  assign tx_halt_o      = halt_r;
  assign int_o          = int_r;
  assign interrupt_enable_reg_o = ier_r;
  assign line_control_reg_o     = lcr_r;
  assign fifo_control_reg_o     = fcr_r;
  assign prdata_o  = rdata_r;
  assign pready_o  = access;
  assign pslverr_o = access && err_r;
endmodule

//--- uafc_pkg.sv
// Constants and types for the UART flow control register block
package uafc_pkg;
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFS_IER   = 8'h00;
  localparam logic [7:0] OFS_ISR   = 8'h04;
  localparam logic [7:0] OFS_LCR   = 8'h08;
  localparam logic [7:0] OFS_MCR   = 8'h0C;
  localparam logic [7:0] OFS_LSR   = 8'h10;
  localparam logic [7:0] OFS_MSR   = 8'h14;
  localparam logic [7:0] OFS_FCR   = 8'h18;
  localparam logic [7:0] OFS_SCR   = 8'h1C;
  localparam logic [7:0] OFS_EFR   = 8'h20;
  localparam logic [7:0] OFS_ISTAT = 8'h24;
  localparam logic [7:0] OFS_IMASK = 8'h28;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_ISR   = 8'h01;
  localparam logic [7:0] RST_LSR   = 8'h60;
  localparam int unsigned EFR_CTS  = 7;
  localparam int unsigned EFR_RTS  = 6;
  localparam int unsigned MCR_DTR  = 0;
  localparam int unsigned MCR_RTS  = 1;
  localparam int unsigned MCR_OUT1 = 2;
  localparam int unsigned MCR_OUT2 = 3;
  localparam int unsigned MCR_LOOP = 4;
  localparam int unsigned LCR_BRK  = 6;
  localparam int unsigned FCR_DMA  = 3;
  localparam int unsigned FCR_TRH  = 7;
  localparam int unsigned FCR_TRL  = 6;
  localparam int unsigned LSR_RDR  = 0;
  localparam int unsigned LSR_THRE = 5;
  localparam int unsigned EV_TRIG  = 0;
  localparam int unsigned EV_HALT  = 1;
  localparam int unsigned EV_RTS   = 2;
  localparam int unsigned EV_MDM   = 3;
  localparam int unsigned EV_N     = 4;
  localparam int unsigned LVL_W    = 7;
  typedef logic [LVL_W-1:0] uafc_lvl_t;
  localparam uafc_lvl_t TRIG_0 = 7'h01;
  localparam uafc_lvl_t TRIG_1 = 7'h10;
  localparam uafc_lvl_t TRIG_2 = 7'h20;
  localparam uafc_lvl_t TRIG_3 = 7'h38;
  localparam uafc_lvl_t FIFO_DEPTH = 7'h40;
  typedef enum logic [1:0] {
    UAFC_RTS_OPEN  = 2'b00,
    UAFC_RTS_SLOW  = 2'b01,
    UAFC_RTS_HELD  = 2'b11
  } uafc_rts_e;
endpackage

//--- uafc_flow_if.sv
// Carrier between the register block and the receive flow controller
`timescale 1ns/10ps
interface uafc_flow_if;
  import uafc_pkg::*;
  logic      enable;
  logic [1:0] trig_sel;
  uafc_lvl_t level;
  logic      trig_hit;
  logic      rts_hold;
  modport ctl (output enable, output trig_sel, output level,
               input trig_hit, input rts_hold);
  modport flow (input enable, input trig_sel, input level,
                output trig_hit, output rts_hold);
endinterface

//--- uafc_sync.sv
// Two flop synchroniser for asynchronous pins
`timescale 1ns/10ps
module uafc_sync #(
  parameter int unsigned       W       = 1,
  parameter logic [W-1:0]      RST_VAL = '1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end
  assign sync_o = sync_r;
endmodule

//--- uafc_rts.sv
// Receive FIFO threshold tracking and automatic RTS throttle
`timescale 1ns/10ps
module uafc_rts
  import uafc_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  uafc_flow_if.flow fl
);
  uafc_rts_e state_r;
  uafc_rts_e state_nxt;
  uafc_lvl_t trig_lvl;
  uafc_lvl_t next_lvl;
  uafc_lvl_t low_lvl;

  always_comb begin
    unique case (fl.trig_sel)
      2'd0: begin
        trig_lvl = TRIG_0;
        next_lvl = TRIG_1;
        low_lvl  = TRIG_0;
      end
      2'd1: begin
        trig_lvl = TRIG_1;
        next_lvl = TRIG_2;
        low_lvl  = TRIG_0;
      end
      2'd2: begin
        trig_lvl = TRIG_2;
        next_lvl = TRIG_3;
        low_lvl  = TRIG_1;
      end
      2'd3: begin
        trig_lvl = TRIG_3;
        next_lvl = FIFO_DEPTH;
        low_lvl  = TRIG_2;
      end
    endcase
  end

  // Hysteresis: raise at the level above, release below the level under
  always_comb begin
    state_nxt = state_r;
    if (!fl.enable) begin
      state_nxt = UAFC_RTS_OPEN;
    end else begin
      unique case (state_r)
        UAFC_RTS_OPEN: begin
          // A jump past both levels throttles at once, no slow step
          if (fl.level >= next_lvl) state_nxt = UAFC_RTS_HELD; // [R5]
          else if (fl.level >= trig_lvl) state_nxt = UAFC_RTS_SLOW; // [R4]
        end
        UAFC_RTS_SLOW: begin
          if (fl.level >= next_lvl) state_nxt = UAFC_RTS_HELD; // [R5]
          else if (fl.level < trig_lvl) state_nxt = UAFC_RTS_OPEN;
        end
        UAFC_RTS_HELD: begin
          if (fl.level < low_lvl) state_nxt = UAFC_RTS_OPEN; // [R6]
        end
        default: state_nxt = UAFC_RTS_OPEN;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= UAFC_RTS_OPEN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign fl.trig_hit = fl.enable && (fl.level >= trig_lvl); // [R4]
  assign fl.rts_hold = (state_r == UAFC_RTS_HELD);
endmodule

//--- uafc_asserts.sv
// Port level checks for the flow control register block
`timescale 1ns/10ps
module uafc_asserts
  import uafc_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic [3:0]        pstrb_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              cts_n_i,
  input wire logic              tx_active_i,
  input wire logic [LVL_W-1:0]  rx_level_i,
  input wire logic [7:0]        fifo_control_reg_o,
  input wire logic              tx_o,
  input wire logic              rts_n_o,
  input wire logic              dtr_n_o,
  input wire logic              rx_dma_ready_o,
  input wire logic              tx_dma_ready_o,
  input wire logic              tx_halt_o,
  input wire logic              int_o
);
  localparam uafc_lvl_t HI_TAB [4] = '{TRIG_1, TRIG_2, TRIG_3, FIFO_DEPTH};
  localparam uafc_lvl_t LO_TAB [4] = '{TRIG_0, TRIG_0, TRIG_1, TRIG_2};
  logic [7:0] efr_r, efr_nxt, mcr_r, mcr_nxt;
  logic       wr_hit;
  logic [1:0] sel;
  // Shadow copies, since the checker cannot see inside the block
  always_comb begin
    wr_hit  = psel_i && penable_i && pwrite_i && pstrb_i[0];
    efr_nxt = (wr_hit && paddr_i == OFS_EFR) ? pwdata_i[7:0] : efr_r;
    mcr_nxt = (wr_hit && paddr_i == OFS_MCR) ? pwdata_i[7:0] : mcr_r;
    sel     = fifo_control_reg_o[FCR_TRH:FCR_TRL];
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      efr_r <= 8'h00;
      mcr_r <= 8'h00;
    end else begin
      efr_r <= efr_nxt;
      mcr_r <= mcr_nxt;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence cts_held_s;
    cts_n_i [*3];
  endsequence
  sequence cts_clear_s;
    !cts_n_i [*3];
  endsequence
  AST_RST_OUT: assert property ($rose(rst_n_i) |->
    {tx_o, rts_n_o, dtr_n_o, rx_dma_ready_o, tx_dma_ready_o, int_o} == 6'h3C)
    else $error("reset output levels wrong");
  AST_DTR: assert property (dtr_n_o == !mcr_r[MCR_DTR])
    else $error("dtr pin does not follow modem control");
  AST_RTS_MAN: assert property (!efr_r[EFR_RTS] |->
    rts_n_o == !mcr_r[MCR_RTS]) else $error("manual rts wrong");
  AST_RTS_UP: assert property (efr_r[EFR_RTS] &&
    rx_level_i >= HI_TAB[sel] |=> rts_n_o || !efr_r[EFR_RTS])
    else $error("rts not raised at next level");
  AST_RTS_DOWN: assert property (efr_r[EFR_RTS] &&
    rx_level_i < LO_TAB[sel] |=> !rts_n_o || !efr_r[EFR_RTS])
    else $error("rts not released below lower level");
  AST_HALT_GAP: assert property ($rose(tx_halt_o) |->
    !$past(tx_active_i) && $past(efr_r[EFR_CTS]))
    else $error("halt raised mid character");
  AST_HALT_ON: assert property (cts_held_s ##0
    (efr_r[EFR_CTS] && !tx_active_i) |=> tx_halt_o)
    else $error("halt missing while cts high");
  AST_HALT_HOLD: assert property (cts_held_s ##0
    (tx_halt_o && efr_r[EFR_CTS]) |=> tx_halt_o || !efr_r[EFR_CTS])
    else $error("halt dropped while cts high");
  AST_HALT_OFF: assert property (cts_clear_s |=> !tx_halt_o)
    else $error("halt kept after cts low");
  AST_EFR_RD: assert property (psel_i && penable_i && !pwrite_i &&
    paddr_i == OFS_EFR |-> prdata_o[5:0] == 6'h00 &&
    prdata_o[31:8] == 24'h00_0000 && prdata_o[EFR_CTS] == efr_r[EFR_CTS])
    else $error("enhanced register read wrong");
endmodule

//--- uafc_modem.sv
// Peer modem model driving the handshake pins of the block
`timescale 1ns/10ps
module uafc_modem (
  input  wire logic ref_clk_i,
  input  wire logic stop_i,
  output logic      cts_n_o,
  output logic      dsr_n_o,
  output logic      ri_n_o,
  output logic      dcd_n_o
);
  // Pin follows the stop request one edge later
  always @(posedge ref_clk_i) begin
    cts_n_o <= stop_i;
  end
  // Unused lines idle at their pull-up level
  assign dsr_n_o = 1'b1;
  assign ri_n_o  = 1'b1;
  assign dcd_n_o = 1'b1;
endmodule

//--- tb_top.sv
// Self-checking bench for the flow control register block
`timescale 1ns/10ps
module tb_top;
  import uafc_pkg::*;
  typedef struct {
    logic       wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } uafc_row_s;
  logic              ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
  logic              pready_o, pslverr_o, cts_n_i, dsr_n_i, ri_n_i, dcd_n_i;
  logic              tx_active_i, tx_o, rts_n_o, dtr_n_o, rx_dma_ready_o;
  logic              tx_dma_ready_o, tx_halt_o, int_o, peer_stop, err_seen;
  logic [APB_AW-1:0] paddr_i;
  logic [7:0]        interrupt_enable_reg_o, line_control_reg_o;
  logic [7:0]        fifo_control_reg_o;
  logic [31:0]       pwdata_i, prdata_o, v;
  logic [3:0]        pstrb_i;
  uafc_lvl_t         rx_level_i;
  int                n_tests, n_mismatch;
  uafc_row_s rows [16] = '{
    '{1'h0, OFS_IER, 8'h00, 8'h00},
    '{1'h0, OFS_ISR, 8'h00, 8'h01},
    '{1'h0, OFS_LCR, 8'h00, 8'h00},
    '{1'h0, OFS_MCR, 8'h00, 8'h00},
    '{1'h0, OFS_LSR, 8'h00, 8'h60},
    '{1'h0, OFS_MSR, 8'h00, 8'h00},
    '{1'h0, OFS_FCR, 8'h00, 8'h00},
    '{1'h0, OFS_EFR, 8'h00, 8'h00},
    '{1'h1, OFS_SCR, 8'hA5, 8'hA5},
    '{1'h1, OFS_SCR, 8'h5A, 8'h5A},
    '{1'h1, OFS_EFR, 8'h3F, 8'h00},
    '{1'h1, OFS_IER, 8'h0F, 8'h0F},
    '{1'h1, OFS_LCR, 8'h03, 8'h03},
    '{1'h1, OFS_ISR, 8'hFF, 8'h01},
    '{1'h1, OFS_MCR, 8'h01, 8'h01},
    '{1'h1, 8'h30,   8'hFF, 8'h00}};
  uafc_top DUT (.*, .tx_serial_i(1'b1), .int_ident_i(7'h00),
    .int_pending_i(1'b0), .line_status_i(8'h60), .tx_fifo_full_i(1'b0));
  uafc_modem u_peer (.ref_clk_i, .stop_i(peer_stop), .cts_n_o(cts_n_i),
    .dsr_n_o(dsr_n_i), .ri_n_o(ri_n_i), .dcd_n_o(dcd_n_i));
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= {24'h00_0000, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    v = prdata_o;
    err_seen = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    // Idle edge keeps the next setup off this time step
    @(posedge ref_clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h00_0000, e}, v);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, tx_active_i} = 5'h00;
    {paddr_i, pwdata_i, rx_level_i} = '0;
    pstrb_i = 4'hF;
    peer_stop = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "table");
    end
    chk("ier copy", 32'h0F, 32'(interrupt_enable_reg_o));
    chk("lcr copy", 32'h03, 32'(line_control_reg_o));
    $display("test table done");
    chk("unmapped error", 32'h1, 32'(err_seen));
    pstrb_i <= 4'hE;
    apb(1'h1, OFS_SCR, 8'h33);
    pstrb_i <= 4'hF;
    rd(OFS_SCR, 8'h5A, "scratch lane off");
    $display("test bus done");
    // Character in flight first, so the halt must wait for its end
    tx_active_i <= 1'b1;
    apb(1'h1, OFS_IMASK, 8'h02);
    apb(1'h1, OFS_EFR, 8'h80);
    cyc(6);
    chk("halt mid char", 32'h0, 32'(tx_halt_o));
    tx_active_i <= 1'b0;
    cyc(3);
    chk("halt", 32'h1, 32'(tx_halt_o));
    tx_active_i <= 1'b1;
    cyc(2);
    chk("halt held", 32'h1, 32'(tx_halt_o));
    chk("halt irq", 32'h1, 32'(int_o));
    apb(1'h1, OFS_IMASK, 8'h00);
    cyc(2);
    chk("masked irq", 32'h0, 32'(int_o));
    apb(1'h1, OFS_ISTAT, 8'h0F);
    apb(1'h1, OFS_IMASK, 8'h02);
    cyc(2);
    chk("cleared irq", 32'h0, 32'(int_o));
    peer_stop <= 1'b0;
    cyc(5);
    chk("resume", 32'h0, 32'(tx_halt_o));
    $display("test cts done");
    apb(1'h1, OFS_MCR, 8'h02);
    apb(1'h1, OFS_FCR, 8'h40);
    apb(1'h1, OFS_ISTAT, 8'h0F);
    apb(1'h1, OFS_IMASK, 8'h01);
    apb(1'h1, OFS_EFR, 8'h40);
    rx_level_i <= TRIG_1;
    cyc(3);
    chk("trigger irq", 32'h1, 32'(int_o));
    rx_level_i <= TRIG_2 - 7'h01;
    cyc(3);
    chk("rts below next", 32'h0, 32'(rts_n_o));
    rx_level_i <= TRIG_2;
    cyc(3);
    chk("rts at next", 32'h1, 32'(rts_n_o));
    rd(OFS_EFR, 8'h40, "efr throttling");
    rx_level_i <= TRIG_0;
    cyc(3);
    chk("rts hysteresis", 32'h1, 32'(rts_n_o));
    rx_level_i <= 7'h00;
    cyc(3);
    chk("rts released", 32'h0, 32'(rts_n_o));
    rd(OFS_EFR, 8'h00, "efr released");
    rx_level_i <= FIFO_DEPTH;
    apb(1'h1, OFS_EFR, 8'h00);
    apb(1'h1, OFS_MCR, 8'h00);
    chk("manual rts off", 32'h1, 32'(rts_n_o));
    apb(1'h1, OFS_MCR, 8'h02);
    chk("manual rts on", 32'h0, 32'(rts_n_o));
    $display("test rts done");
    rst_n_i <= 1'b0;
    cyc(2);
    chk("reset pins", 32'h3C, 32'({tx_o, rts_n_o, dtr_n_o, rx_dma_ready_o,
      tx_dma_ready_o, int_o}));
    rst_n_i <= 1'b1;
    rd(OFS_MCR, 8'h00, "mcr after reset");
    rd(OFS_FCR, 8'h00, "fcr after reset");
    // Peer is clear now, so the synced pin flips after release
    rd(OFS_MSR, 8'h11, "msr pins");
    rd(OFS_MSR, 8'h10, "msr read clears");
    $display("test reset done");
    apb(1'h1, OFS_MCR, 8'h13);
    rd(OFS_MSR, 8'h32, "loopback msr");
    apb(1'h1, OFS_LCR, 8'h40);
    cyc(1);
    chk("break", 32'h0, 32'(tx_o));
    chk("lcr break copy", 32'h40, 32'(line_control_reg_o));
    apb(1'h1, OFS_FCR, 8'h48);
    apb(1'h1, OFS_EFR, 8'h40);
    cyc(1);
    chk("dma rx ready", 32'h0, 32'(rx_dma_ready_o));
    chk("fcr copy", 32'h48, 32'(fifo_control_reg_o));
    chk("rts full", 32'h1, 32'(rts_n_o));
    $display("test modes done");
    end_of_test();
  end
endmodule
bind uafc_top uafc_asserts u_chk (.*);
